// ---- design/sar_cfg.svh ----
// Purpose: shared constants for the converter serial readout link
// Assumes: 100 MHz reference clock on both ends
// Notes:   counts are derived from the printed times
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_RES_W          16
`define SAR_CLK_MHZ        100
`define SAR_CONV_TIME_NS   710
// device finishes by the longest time: round down
`define SAR_CONV_CYC       ((`SAR_CONV_TIME_NS * `SAR_CLK_MHZ) / 1000)
// host waits at least that time: round up
`define SAR_WAIT_CYC       ((`SAR_CONV_TIME_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_CHAIN_DLY      16
`define SAR_SCK_HALF       4
`define SAR_SEL_LEAD       3
// chain shifts on the fall after the load, so sampling starts right behind it
`define SAR_LOAD_FALLS     3
`define SAR_CODE_MAX       16'hffff
`define SAR_CODE_MIN       16'h0000
`endif

// ---- design/sar_pkg.sv ----
// Purpose: types for the converter serial readout link
// Assumes: constants live in sar_cfg.svh
// Notes:   host states are gray coded in declaration order
package sar_pkg;
    typedef logic [15:0] sar_word_t;
    typedef enum logic [2:0] {
        SAR_IDLE  = 3'h0,
        SAR_SETUP = 3'h1,
        SAR_CONV  = 3'h3,
        SAR_LEAD  = 3'h2,
        SAR_WAITB = 3'h6,
        SAR_SHIFT = 3'h7,
        SAR_DONE  = 3'h5
    } sar_hst_t;
endpackage

// ---- design/sar_link_if.sv ----
// Purpose: pins between host controller and converter
// Assumes: host makes the serial clock
// Notes:   sdo_line resolves the released output
`timescale 1ns/1ps
interface sar_link_if;
    logic convert_start;
    logic sdi;
    logic sck;
    logic sdo;
    logic sdo_oe;
    wire  sdo_line;
    // no pull on the line: a released output reads back inverted
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    modport dev (input convert_start, input sdi, input sck, output sdo, output sdo_oe);
    modport host (output convert_start, output sdi, output sck, input sdo_line);
endinterface

// ---- design/sar_dev.sv ----
// Purpose: converter end: conversion timing and serial readout
// Assumes: serial clock runs free from the host divider
// Notes:   conversion runs on ref_clk_i, shifting on falling sck
//
// Function
// - each convert_start rise starts a conversion
// - sdi low at rise selects daisy chain
// - sdi high at rise selects select mode
// - select mode drives output while convert_start low, until bit 0 is out
// - select mode enables output on sdi or start low
// - low at completion enables busy indicator
// - host reads chain while convert_start held high
// - chain passes sdi to sdo after 16 clocks
// - chain mode drives sdo all the time; only select mode releases it to share a line
// - result leaves on sdo, synced to sck
// - host clocks one bit per sck cycle
// - msb first, bit 15 first
// - straight binary, saturating at both ends
// - conversion timed by internal clock only
// - host waits conversion time before reading
`timescale 1ns/1ps
`include "sar_cfg.svh"
module sar_dev #(
    parameter int RES_W    = `SAR_RES_W,
    parameter int CONV_CYC = `SAR_CONV_CYC
) (
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    sar_link_if.dev                link,
    input  wire sar_pkg::sar_word_t sample_i,
    input  wire logic              over_i,
    input  wire logic              under_i,
    output logic                   conv_busy_o,
    output logic                   chain_mode_o
);
    import sar_pkg::*;

    // ref domain: pin synchronisers
    logic            cs_m_reg;
    logic            cs_s_reg;
    logic            cs_q_reg;
    logic            di_m_reg;
    logic            di_s_reg;
    logic            cs_rise;
    logic [7:0]      cnt_reg;
    logic            busy_reg;
    logic            chain_reg;
    logic            bsy_en_reg;
    logic            tgl_reg;
    sar_word_t       smp_reg;
    sar_word_t       res_reg;
    sar_word_t       smp_next;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_m_reg <= 1'b0;
            cs_s_reg <= 1'b0;
            cs_q_reg <= 1'b0;
            di_m_reg <= 1'b1;
            di_s_reg <= 1'b1;
        end else begin
            cs_m_reg <= link.convert_start;
            cs_s_reg <= cs_m_reg;
            cs_q_reg <= cs_s_reg;
            di_m_reg <= link.sdi;
            di_s_reg <= di_m_reg;
        end
    end

    assign cs_rise = cs_s_reg & ~cs_q_reg;

    always_comb begin
        if (over_i) begin
            smp_next = `SAR_CODE_MAX;
        end else if (under_i) begin
            smp_next = `SAR_CODE_MIN;
        end else begin
            smp_next = sample_i;
        end
    end

    // a new rise restarts the conversion even if one is running
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_reg   <= 1'b0;
            cnt_reg    <= 8'h00;
            chain_reg  <= 1'b0;
            bsy_en_reg <= 1'b0;
            tgl_reg    <= 1'b0;
            smp_reg    <= '0;
            res_reg    <= '0;
        end else if (cs_rise) begin
            busy_reg  <= 1'b1;
            cnt_reg   <= 8'(CONV_CYC - 1);
            chain_reg <= ~di_s_reg;
            smp_reg   <= smp_next;
        end else if (busy_reg) begin
            if (cnt_reg == 8'h00) begin
                busy_reg   <= 1'b0;
                res_reg    <= smp_reg;
                tgl_reg    <= ~tgl_reg;
                bsy_en_reg <= ~chain_reg & (~di_s_reg | ~cs_s_reg);
            end else begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    assign conv_busy_o  = busy_reg;
    assign chain_mode_o = chain_reg;

    // sck domain: result crosses by toggle, res_reg held until next result
    logic            tg_m_reg;
    logic            tg_s_reg;
    logic            tg_q_reg;
    logic            md_m_reg;
    logic            md_s_reg;
    logic            be_m_reg;
    logic            be_s_reg;
    logic            c2_m_reg;
    logic            c2_s_reg;
    logic            d2_m_reg;
    logic            d2_s_reg;
    logic            fresh;
    logic            sel_en;
    sar_word_t       sh_reg;
    logic            have_reg;
    logic            run_reg;
    logic [4:0]      bit_reg;
    logic            sdo_reg;
    logic            oe_reg;

    always_ff @(negedge link.sck or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tg_m_reg <= 1'b0;
            tg_s_reg <= 1'b0;
            tg_q_reg <= 1'b0;
            md_m_reg <= 1'b0;
            md_s_reg <= 1'b0;
            be_m_reg <= 1'b0;
            be_s_reg <= 1'b0;
            c2_m_reg <= 1'b0;
            c2_s_reg <= 1'b0;
            d2_m_reg <= 1'b1;
            d2_s_reg <= 1'b1;
        end else begin
            tg_m_reg <= tgl_reg;
            tg_s_reg <= tg_m_reg;
            tg_q_reg <= tg_s_reg;
            md_m_reg <= chain_reg;
            md_s_reg <= md_m_reg;
            be_m_reg <= bsy_en_reg;
            be_s_reg <= be_m_reg;
            c2_m_reg <= link.convert_start;
            c2_s_reg <= c2_m_reg;
            d2_m_reg <= link.sdi;
            d2_s_reg <= d2_m_reg;
        end
    end

    assign fresh  = tg_s_reg ^ tg_q_reg;
    assign sel_en = ~c2_s_reg | ~d2_s_reg;

    always_ff @(negedge link.sck or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_reg   <= '0;
            have_reg <= 1'b0;
            run_reg  <= 1'b0;
            bit_reg  <= 5'h00;
            sdo_reg  <= 1'b0;
            oe_reg   <= 1'b0;
        end else if (md_s_reg) begin
            // chain: sdi comes from a neighbour on this same sck, so no sync
            run_reg  <= 1'b0;
            have_reg <= 1'b0;
            oe_reg   <= 1'b1;
            if (fresh) begin
                sh_reg  <= res_reg;
                sdo_reg <= res_reg[RES_W-1];
            end else if (c2_s_reg) begin
                sh_reg  <= {sh_reg[RES_W-2:0], link.sdi};
                sdo_reg <= sh_reg[RES_W-2];
            end
        end else if (!sel_en) begin
            oe_reg  <= 1'b0;
            run_reg <= 1'b0;
            bit_reg <= 5'h00;
            if (fresh) begin
                sh_reg   <= res_reg;
                have_reg <= 1'b1;
            end
        end else if (run_reg) begin
            if (bit_reg == 5'(RES_W)) begin
                oe_reg <= 1'b0;
            end else begin
                oe_reg  <= 1'b1;
                sdo_reg <= sh_reg[RES_W-1];
                sh_reg  <= {sh_reg[RES_W-2:0], 1'b0};
                bit_reg <= bit_reg + 5'h01;
            end
        end else if (have_reg) begin
            oe_reg   <= 1'b1;
            have_reg <= 1'b0;
            run_reg  <= 1'b1;
            bit_reg  <= 5'h01;
            sdo_reg  <= sh_reg[RES_W-1];
            sh_reg   <= {sh_reg[RES_W-2:0], 1'b0};
        end else if (fresh && be_s_reg) begin
            // busy indicator: high for one clock, msb follows
            oe_reg   <= 1'b1;
            sdo_reg  <= 1'b1;
            sh_reg   <= res_reg;
            have_reg <= 1'b1;
        end else if (fresh) begin
            oe_reg  <= 1'b1;
            run_reg <= 1'b1;
            bit_reg <= 5'h01;
            sdo_reg <= res_reg[RES_W-1];
            sh_reg  <= {res_reg[RES_W-2:0], 1'b0};
        end else begin
            // no result yet: a low line tells the host to keep waiting
            oe_reg  <= 1'b1;
            sdo_reg <= 1'b0;
        end
    end

    assign link.sdo    = sdo_reg;
    assign link.sdo_oe = oe_reg;
endmodule

// ---- design/sar_host.sv ----
// Purpose: host end: conversion start, serial clock, readout
// Assumes: serial clock divided from ref_clk_i, runs free
// Notes:   convert_start changes at sck rise events, sdi also when a start is taken, sdo sampled at falls
`timescale 1ns/1ps
`include "sar_cfg.svh"
module sar_host #(
    parameter int RES_W     = `SAR_RES_W,
    parameter int CHAIN_LEN = 1,
    parameter int WAIT_CYC  = `SAR_WAIT_CYC,
    parameter int SCK_HALF  = `SAR_SCK_HALF
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       arst_n_i,
    sar_link_if.host                        link,
    input  wire logic                       start_i,
    input  wire logic                       chain_i,
    input  wire logic                       busy_ind_i,
    output logic [RES_W*CHAIN_LEN-1:0]      data_o,
    output logic                            done_o,
    output logic                            busy_o
);
    import sar_pkg::*;
    localparam int TOT = RES_W * CHAIN_LEN;
    localparam int BW  = $clog2(TOT + 1);

    logic [3:0]      div_reg;
    logic            sck_reg;
    logic            rise_ev;
    logic            fall_ev;

    assign rise_ev = (div_reg == 4'(SCK_HALF - 1)) & ~sck_reg;
    assign fall_ev = (div_reg == 4'(SCK_HALF - 1)) & sck_reg;

    // free-running clock lets the converter take its result across
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= 4'h0;
            sck_reg <= 1'b0;
        end else if (div_reg == 4'(SCK_HALF - 1)) begin
            div_reg <= 4'h0;
            sck_reg <= ~sck_reg;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    logic            so_m_reg;
    logic            so_s_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            so_m_reg <= 1'b0;
            so_s_reg <= 1'b0;
        end else begin
            so_m_reg <= link.sdo_line;
            so_s_reg <= so_m_reg;
        end
    end

    sar_hst_t        st_reg;
    logic            cs_reg;
    logic            sdi_reg;
    logic            chain_reg;
    logic            bi_reg;
    logic            drop_reg;
    logic [7:0]      wcnt_reg;
    logic [2:0]      fcnt_reg;
    logic [BW-1:0]   bits_reg;
    logic [TOT-1:0]  sh_reg;
    logic [TOT-1:0]  data_reg;
    logic            done_reg;
    logic            busy_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg    <= SAR_IDLE;
            cs_reg    <= 1'b0;
            sdi_reg   <= 1'b1;
            chain_reg <= 1'b0;
            bi_reg    <= 1'b0;
            drop_reg  <= 1'b0;
            wcnt_reg  <= 8'h00;
            fcnt_reg  <= 3'h0;
            bits_reg  <= '0;
            sh_reg    <= '0;
            data_reg  <= '0;
            done_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            // busy ends after the done pulse unless a new start is taken
            if (done_reg) begin
                busy_reg <= 1'b0;
            end
            case (st_reg)
                SAR_IDLE: begin
                    if (start_i) begin
                        sdi_reg   <= ~chain_i;
                        chain_reg <= chain_i;
                        bi_reg    <= busy_ind_i & ~chain_i;
                        busy_reg  <= 1'b1;
                        st_reg    <= SAR_SETUP;
                    end
                end
                SAR_SETUP: begin
                    if (rise_ev) begin
                        cs_reg   <= 1'b1;
                        wcnt_reg <= 8'(WAIT_CYC);
                        fcnt_reg <= 3'h0;
                        drop_reg <= 1'b0;
                        st_reg   <= SAR_CONV;
                    end
                end
                SAR_CONV: begin
                    if (wcnt_reg != 8'h00) begin
                        wcnt_reg <= wcnt_reg - 8'h01;
                    end else if (fall_ev && fcnt_reg != 3'(`SAR_LOAD_FALLS)) begin
                        fcnt_reg <= fcnt_reg + 3'h1;
                    end
                    if (bi_reg && rise_ev) begin
                        if (drop_reg) begin
                            fcnt_reg <= 3'h0;
                            st_reg   <= SAR_WAITB;
                        end
                        drop_reg <= 1'b1;
                        sdi_reg  <= ~drop_reg;
                    end else if (!bi_reg && rise_ev && wcnt_reg == 8'h00
                                 && fcnt_reg == 3'(`SAR_LOAD_FALLS)) begin
                        bits_reg <= '0;
                        fcnt_reg <= 3'h0;
                        if (chain_reg) begin
                            st_reg <= SAR_SHIFT;
                        end else begin
                            cs_reg <= 1'b0;
                            st_reg <= SAR_LEAD;
                        end
                    end
                end
                SAR_LEAD: begin
                    if (fall_ev) begin
                        fcnt_reg <= fcnt_reg + 3'h1;
                        if (fcnt_reg == 3'(`SAR_SEL_LEAD - 1)) begin
                            st_reg <= SAR_SHIFT;
                        end
                    end
                end
                SAR_WAITB: begin
                    // sdo stays released until the converter has synced sdi low
                    if (fall_ev && fcnt_reg != 3'(`SAR_SEL_LEAD)) begin
                        fcnt_reg <= fcnt_reg + 3'h1;
                    end else if (fall_ev && so_s_reg == 1'b1) begin
                        bits_reg <= '0;
                        st_reg   <= SAR_SHIFT;
                    end
                end
                SAR_SHIFT: begin
                    if (fall_ev) begin
                        sh_reg   <= {sh_reg[TOT-2:0], so_s_reg};
                        bits_reg <= bits_reg + BW'(1);
                        if (bits_reg == BW'(TOT - 1)) begin
                            st_reg <= SAR_DONE;
                        end
                    end
                end
                SAR_DONE: begin
                    if (rise_ev) begin
                        cs_reg   <= 1'b0;
                        sdi_reg  <= 1'b1;
                        data_reg <= sh_reg;
                        done_reg <= 1'b1;
                        st_reg   <= SAR_IDLE;
                    end
                end
                default: begin
                    st_reg <= SAR_IDLE;
                end
            endcase
        end
    end

    assign link.sck           = sck_reg;
    assign link.convert_start = cs_reg;
    assign link.sdi           = sdi_reg;
    assign data_o             = data_reg;
    assign done_o             = done_reg;
    assign busy_o             = busy_reg;
endmodule

// ---- tb/sar_link_checker.sv ----
// Purpose: protocol checks on the link between host and converter
// Assumes: sck made by the host divider, half period of 4 ref cycles
// Notes:   sck-domain checks sample at falls, where sdo is settled
`timescale 1ns/1ps
module sar_link_checker #(
    parameter int WAIT_CYC = 71
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic convert_start,
    input wire logic sdi,
    input wire logic sck,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic [9:0] hi_cnt_reg;
    logic       chain_reg;
    logic       busy_rd_reg;

    // saturating count of cycles convert_start has stood high
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt_reg <= 10'h000;
        end else if (!convert_start) begin
            hi_cnt_reg <= 10'h000;
        end else if (hi_cnt_reg != 10'h3ff) begin
            hi_cnt_reg <= hi_cnt_reg + 10'h001;
        end
    end

    // mode strap seen at the start edge
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chain_reg <= 1'b0;
        end else if ($rose(convert_start)) begin
            chain_reg <= !sdi;
        end
    end

    // busy readout runs under a high start, so its closing fall selects nothing new
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_rd_reg <= 1'b0;
        end else if ($rose(convert_start)) begin
            busy_rd_reg <= 1'b0;
        end else if (convert_start && !sdi) begin
            busy_rd_reg <= 1'b1;
        end
    end

    AST_SDO_ON_FALL: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $changed(sdo) |-> $fell(sck)) else $error("sdo moved away from a sck fall");
    AST_OE_NEEDS_LOW: assert property (@(negedge sck) disable iff (!arst_n_i)
        (convert_start && sdi) [*4] |-> !sdo_oe) else $error("sdo driven while deselected");
    AST_STRAP_HELD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(convert_start) |-> $stable(sdi)) else $error("sdi moved at start edge");
    AST_START_WIDTH: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(convert_start) |=> convert_start [*8]) else $error("start pulse too short");
    AST_SCK_HIGH: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(sck) |-> sck [*4] ##1 !sck) else $error("sck high phase wrong");
    AST_SCK_LOW: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(sck) |-> !sck [*4] ##1 sck) else $error("sck low phase wrong");
    AST_CONV_WAIT: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(convert_start) |-> hi_cnt_reg >= WAIT_CYC) else $error("read before result");
    AST_START_ON_RISE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $changed(convert_start) |-> $rose(sck)) else $error("start moved off a sck rise");
    AST_OE_AFTER_SELECT: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(convert_start) && sdi && !chain_reg && !busy_rd_reg |-> ##[1:200] sdo_oe)
        else $error("select readout never drove sdo");
endmodule

// ---- tb/sar_adc_serial_readout_tb.sv ----
// Purpose: host and converter joined, user sides driven and scored
// Assumes: one converter on the link, host chain length of one
// Notes:   expectations queued at start, scored at each done pulse
`timescale 1ns/1ps
`include "sar_cfg.svh"
module sar_adc_serial_readout_tb;
    import sar_pkg::*;
    logic        ref_clk_i;
    logic        arst_n_i;
    logic        start;
    logic        chain;
    logic        busy_ind;
    logic        over;
    logic        under;
    logic        done;
    logic        busy;
    logic        conv_busy;
    logic        chain_mode;
    sar_word_t   sample;
    sar_word_t   data;
    logic [16:0] exp_v;
    logic [16:0] exp_q[$];
    logic [31:0] lfsr = 32'heb6c42ba;
    sar_word_t   codes[4] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff};
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_done = 0;
    int          hi_w = 0;

    sar_link_if link_a ();
    sar_host u_sar_host (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(link_a),
        .start_i(start), .chain_i(chain), .busy_ind_i(busy_ind), .data_o(data),
        .done_o(done), .busy_o(busy));
    sar_dev u_sar_dev (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(link_a),
        .sample_i(sample), .over_i(over), .under_i(under), .conv_busy_o(conv_busy),
        .chain_mode_o(chain_mode));
    sar_link_checker #(.WAIT_CYC(`SAR_WAIT_CYC)) chk_link (.ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i), .convert_start(link_a.convert_start), .sdi(link_a.sdi),
        .sck(link_a.sck), .sdo(link_a.sdo), .sdo_oe(link_a.sdo_oe));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one transfer; poke repeats start while busy, which must be ignored
    task automatic xfer(input logic ch, input logic bi, input logic ov, input logic un,
                        input sar_word_t s, input logic poke);
        int want;
        want = n_done + 1;
        @(negedge ref_clk_i);
        sample = s;
        over = ov;
        under = un;
        chain = ch;
        busy_ind = bi & ~ch;
        start = 1'b1;
        exp_q.push_back({ch, ov ? 16'hffff : (un ? 16'h0000 : s)});
        @(negedge ref_clk_i);
        start = 1'b0;
        check({15'h0000, busy}, 16'h0001);
        if (poke) begin
            repeat (30) @(negedge ref_clk_i);
            start = 1'b1;
            @(negedge ref_clk_i);
            start = 1'b0;
        end
        for (int i = 0; i < 4000 && n_done < want; i++) @(negedge ref_clk_i);
        if (n_done < want) begin
            n_mismatch++;
            $display("MISMATCH %0t: no done pulse", $time);
            stop_test();
        end
    endtask

    // scoring side: oldest note against each result
    always @(negedge ref_clk_i) begin
        if (arst_n_i === 1'b1 && done === 1'b1) begin
            n_done++;
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~{chain_mode, data};
            check(data, exp_v[15:0]);
            check({15'h0000, chain_mode}, {15'h0000, exp_v[16]});
        end
        if (arst_n_i !== 1'b1) begin
            hi_w = 0;
        end else if (conv_busy === 1'b1) begin
            hi_w++;
        end else if (hi_w > 0) begin
            check({15'h0000, hi_w <= `SAR_CONV_CYC && hi_w >= 50}, 16'h0001);
            hi_w = 0;
        end
    end

    initial begin
        arst_n_i = 1'b0;
        start = 1'b0;
        chain = 1'b0;
        busy_ind = 1'b0;
        over = 1'b0;
        under = 1'b0;
        sample = 16'h0000;
        repeat (20) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        // select, select with busy indicator, chain, over the edge codes
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 4; k++) begin
                xfer(m == 2, m == 1, 1'b0, 1'b0, codes[k], k == 3);
            end
        end
        xfer(1'b0, 1'b0, 1'b1, 1'b0, 16'h1234, 1'b0);
        xfer(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234, 1'b0);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 16'h1234, 1'b0);
        repeat (12) begin
            lfsr = lfsr_next(lfsr);
            xfer(lfsr[16], lfsr[17], lfsr[18] & lfsr[19], lfsr[20] & lfsr[21], lfsr[15:0], 1'b0);
        end
        // reset cuts a chain transfer during its conversion
        @(negedge ref_clk_i);
        chain = 1'b1;
        start = 1'b1;
        @(negedge ref_clk_i);
        start = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        arst_n_i = 1'b0;
        exp_q.delete();
        repeat (3) @(negedge ref_clk_i);
        check({9'h000, done, busy, conv_busy, chain_mode, link_a.sdo_oe, link_a.convert_start,
               link_a.sck}, {9'h000, 7'h00});
        check({15'h0000, link_a.sdi}, 16'h0001);
        check(data, 16'h0000);
        repeat (20) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'ha5c3, 1'b0);
        repeat (100) @(negedge ref_clk_i);
        check({15'h0000, exp_q.size() == 0}, 16'h0001);
        stop_test();
    end
endmodule
